// [hdl/ext_irq_pkg.sv]
// register map, field layout and timing constants of the pin interrupt block
package ext_irq_pkg;
  localparam int unsigned NUM_DED = 3;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BANK_W = 8;
  localparam int unsigned NUM_PC = 32;
  localparam logic [11:0] ADDR_SENSE = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_BANK_EN = 12'h00c;
  localparam logic [11:0] ADDR_BANK_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_PIN_MASK0 = 12'h014;
  localparam logic [11:0] ADDR_CTRL = 12'h024;
  localparam logic [11:0] ADDR_PIN_STATE = 12'h028;
  localparam logic [11:0] ADDR_DED_STATE = 12'h02c;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [7:0] SENSE_WMASK = 8'h3f;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] BANK_EN_RESET = 8'h00;
  localparam logic [7:0] PIN_MASK_RESET = 8'h00;
  localparam int unsigned SENSE_W = 2;
  localparam int unsigned CTRL_GIE = 0;
  localparam int unsigned CTRL_SLEEP = 1;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MIN_PULSE_NS = 50;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ) / 1000;
endpackage

// [hdl/ext_pin_change_irq.sv]
// dedicated-pin and pin-change interrupt logic with apb registers
//
// Behaviour
// - pins raise interrupts from their level even when driven as outputs
// - 32 pin-change inputs form four banks of eight, each with own request
// - pin-change capture goes through clocked synchronisers and needs the system clock
// - sense field: 00 low level, 01 any edge, 10 falling, 11 rising
// - sense register holds three fields in bits 5..0; bits 7..6 read zero
// - enabled low-level pin requests continuously while pin stays low
// - dedicated pin levels and edges are captured by clocked synchronisers
// - low level gone before start-up ends gives no interrupt
// - pulses at least 50 ns wide are registered
// - dedicated dispatch needs global enable and its mask bit 2..0
// - dedicated flag set on trigger, cleared on entry or write-one
// - flag stays zero while pin is in low-level sensing
// - sleep with pins disabled gates their inputs; change may set flags
// - bank dispatch needs its enable bit 3..0 and the global enable
// - bank flag set on change, cleared on entry or write-one
// - a pin feeds its bank only when its mask bit is set
// - per-pin masks reset to zero and are read/write
`timescale 1ns/1ps
module ext_pin_change_irq (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] dedicated_irq_pins,
  input wire logic [31:0] pin_change_inputs,
  input wire logic [2:0] ded_irq_ack,
  input wire logic [3:0] bank_irq_ack,
  output logic [2:0] ded_irq_req,
  output logic [3:0] pin_change_bank_irq
);

  // three-stage synchronisers; stage 1 is only read by stage 2
  logic [2:0] ded_s1, ded_s2, ded_s3;
  logic [31:0] pc_s1, pc_s2, pc_s3;
  logic [2:0] ded_stable;
  logic [31:0] pc_stable;

  logic [7:0] ext_irq_sense_control;
  logic [2:0] ext_irq_enable_mask;
  logic [2:0] ext_irq_flags;
  logic [3:0] pin_change_bank_enable;
  logic [3:0] pin_change_bank_flags;
  logic [7:0] bank_pin_mask [4];
  logic global_irq_enable;
  logic sleep_active;

  logic wr_access;
  logic [2:0] ded_event;
  logic [2:0] ded_level_req;
  logic [3:0] bank_event;
  logic [2:0] ded_seen;

  function automatic logic [1:0] sense_of(input logic [7:0] ctl,
                                          input int unsigned idx);
    sense_of = ctl[idx*ext_irq_pkg::SENSE_W +: ext_irq_pkg::SENSE_W];
  endfunction

  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] base);
    reg_hit = (a == base);
  endfunction

  // a change counts once stages 2 and 3 agree; dedicated stages reset
  // high like the idle pin, so leaving reset shows no false falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ded_s1 <= 3'h7;
      ded_s2 <= 3'h7;
      ded_s3 <= 3'h7;
      pc_s1 <= 32'h0;
      pc_s2 <= 32'h0;
      pc_s3 <= 32'h0;
    end else begin
      ded_s1 <= dedicated_irq_pins;
      ded_s2 <= ded_s1;
      ded_s3 <= ded_s2;
      pc_s1 <= pin_change_inputs;
      pc_s2 <= pc_s1;
      pc_s3 <= pc_s2;
    end
  end

  // stable copies; dedicated ones reset to ones so a pulled-up idle pin is no edge, pin-change ones reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ded_stable <= 3'h7;
      pc_stable <= 32'h0;
      ded_seen <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ded_s2[i] == ded_s3[i]) begin
          ded_stable[i] <= ded_s3[i];
        end
      end
      for (int i = 0; i < 32; i++) begin
        if (pc_s2[i] == pc_s3[i]) begin
          pc_stable[i] <= pc_s3[i];
        end
      end
      ded_seen <= 3'h7;
    end
  end

  // a gated input during sleep with the pin disabled reads as low
  logic [2:0] ded_gated;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ded_gated[i] = ded_stable[i] &
                     ~(sleep_active & ~ext_irq_enable_mask[i]);
    end
  end

  logic [2:0] ded_prev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ded_prev <= 3'h7;
    end else begin
      ded_prev <= ded_gated;
    end
  end

  // edge decode per sense field, level request while pin held low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      case (sense_of(ext_irq_sense_control, i))
        ext_irq_pkg::SENSE_ANY: ded_event[i] = ded_prev[i] ^ ded_gated[i];
        ext_irq_pkg::SENSE_FALL: ded_event[i] = ded_prev[i] & ~ded_gated[i];
        ext_irq_pkg::SENSE_RISE: ded_event[i] = ~ded_prev[i] & ded_gated[i];
        default: ded_event[i] = 1'b0;
      endcase
      ded_level_req[i] =
        (sense_of(ext_irq_sense_control, i) == ext_irq_pkg::SENSE_LOW) &&
        ~ded_gated[i] && ded_seen[i];
    end
  end

  // pin-change banks: only masked-in pins, mask change is not an event
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bank_event[b] = |((pc_s3[b*8 +: 8] ^ pc_stable[b*8 +: 8]) &
                        {8{1'b1}} & (pc_s3[b*8 +: 8] ~^ pc_s2[b*8 +: 8]) &
                        bank_pin_mask[b]);
    end
  end

  // a write lands only at the edge that completes the access phase
  assign wr_access = psel & penable & pwrite & pready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_irq_sense_control <= ext_irq_pkg::SENSE_RESET;
      ext_irq_enable_mask <= 3'h0;
      pin_change_bank_enable <= 4'h0;
      global_irq_enable <= 1'b0;
      sleep_active <= 1'b0;
    end else if (wr_access) begin
      if (reg_hit(paddr, ext_irq_pkg::ADDR_SENSE)) begin
        ext_irq_sense_control <= pwdata[7:0] &
                                 ext_irq_pkg::SENSE_WMASK;
      end
      if (reg_hit(paddr, ext_irq_pkg::ADDR_MASK)) begin
        ext_irq_enable_mask <= pwdata[2:0];
      end
      if (reg_hit(paddr, ext_irq_pkg::ADDR_BANK_EN)) begin
        pin_change_bank_enable <= pwdata[3:0];
      end
      if (reg_hit(paddr, ext_irq_pkg::ADDR_CTRL)) begin
        global_irq_enable <= pwdata[ext_irq_pkg::CTRL_GIE];
        sleep_active <= pwdata[ext_irq_pkg::CTRL_SLEEP];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 4; b++) begin
        bank_pin_mask[b] <= ext_irq_pkg::PIN_MASK_RESET;
      end
    end else if (wr_access) begin
      for (int b = 0; b < 4; b++) begin
        if (reg_hit(paddr, ext_irq_pkg::ADDR_PIN_MASK0 + 12'(4 * b))) begin
          bank_pin_mask[b] <= pwdata[7:0];
        end
      end
    end
  end

  // set beats write-one clear and hardware acknowledge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_irq_flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sense_of(ext_irq_sense_control, i) == ext_irq_pkg::SENSE_LOW) begin
          ext_irq_flags[i] <= 1'b0;
        end else if (ded_event[i]) begin
          ext_irq_flags[i] <= 1'b1;
        end else if (ded_irq_ack[i] ||
                     (wr_access && reg_hit(paddr, ext_irq_pkg::ADDR_FLAGS) &&
                      pwdata[i])) begin
          ext_irq_flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_change_bank_flags <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (bank_event[b]) begin
          pin_change_bank_flags[b] <= 1'b1;
        end else if (bank_irq_ack[b] ||
                     (wr_access &&
                      reg_hit(paddr, ext_irq_pkg::ADDR_BANK_FLAGS) &&
                      pwdata[b])) begin
          pin_change_bank_flags[b] <= 1'b0;
        end
      end
    end
  end

  // requests toward the vector dispatch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ded_irq_req <= 3'h0;
      pin_change_bank_irq <= 4'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ded_irq_req[i] <= global_irq_enable & ext_irq_enable_mask[i] &
                          (ext_irq_flags[i] | ded_level_req[i]);
      end
      pin_change_bank_irq <= {4{global_irq_enable}} &
                             pin_change_bank_enable &
                             pin_change_bank_flags;
    end
  end

  // zero-wait apb slave; unmapped addresses error and read zero
  logic mapped;
  always_comb begin
    mapped = reg_hit(paddr, ext_irq_pkg::ADDR_SENSE) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_MASK) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_FLAGS) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_BANK_EN) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_BANK_FLAGS) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_CTRL) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_PIN_STATE) ||
             reg_hit(paddr, ext_irq_pkg::ADDR_DED_STATE) ||
             (paddr >= ext_irq_pkg::ADDR_PIN_MASK0 &&
              paddr < ext_irq_pkg::ADDR_CTRL && paddr[1:0] == 2'h0);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          ext_irq_pkg::ADDR_SENSE: prdata <= {24'h0, ext_irq_sense_control};
          ext_irq_pkg::ADDR_MASK: prdata <= {29'h0, ext_irq_enable_mask};
          ext_irq_pkg::ADDR_FLAGS: prdata <= {29'h0, ext_irq_flags};
          ext_irq_pkg::ADDR_BANK_EN: prdata <= {28'h0, pin_change_bank_enable};
          ext_irq_pkg::ADDR_BANK_FLAGS:
            prdata <= {28'h0, pin_change_bank_flags};
          ext_irq_pkg::ADDR_CTRL:
            prdata <= {30'h0, sleep_active, global_irq_enable};
          ext_irq_pkg::ADDR_PIN_STATE: prdata <= pc_stable;
          ext_irq_pkg::ADDR_DED_STATE: prdata <= {29'h0, ded_stable};
          default: begin
            for (int b = 0; b < 4; b++) begin
              if (reg_hit(paddr,
                          ext_irq_pkg::ADDR_PIN_MASK0 + 12'(4 * b))) begin
                prdata <= {24'h0, bank_pin_mask[b]};
              end
            end
          end
        endcase
      end
    end
  end

  a_sense_reserved: assert property (@(posedge clk)
    disable iff (rst) ext_irq_sense_control[7:6] == 2'h0)
    else $error("reserved sense bits set");

  a_level_flag_zero: assert property (@(posedge clk)
    disable iff (rst)
    (sense_of(ext_irq_sense_control, 0) == ext_irq_pkg::SENSE_LOW) |=>
    !ext_irq_flags[0] || !$past(sense_of(ext_irq_sense_control, 0) ==
                               ext_irq_pkg::SENSE_LOW))
    else $error("flag set in level mode");

  a_ded_dispatch: assert property (@(posedge clk)
    disable iff (rst)
    ded_irq_req[0] |-> $past(global_irq_enable && ext_irq_enable_mask[0]))
    else $error("dedicated request without enables");

  a_bank_dispatch: assert property (@(posedge clk)
    disable iff (rst) pin_change_bank_irq[1] |->
    $past(global_irq_enable && pin_change_bank_enable[1]))
    else $error("bank request without enables");

  a_ded_flag_set: assert property (@(posedge clk)
    disable iff (rst) ded_event[1] && sense_of(ext_irq_sense_control, 1) !=
    ext_irq_pkg::SENSE_LOW |=> ext_irq_flags[1])
    else $error("dedicated flag not set");

  // an accepted event must win against any clear in the same cycle
  a_bank_set_wins: assert property (@(posedge clk)
    disable iff (rst) bank_event[2] |=> pin_change_bank_flags[2])
    else $error("bank event lost to clear");

  a_mask_ignore: assert property (@(posedge clk)
    disable iff (rst) bank_pin_mask[0] == 8'h0 |-> !bank_event[0])
    else $error("masked bank produced event");

  a_level_hold: assert property (@(posedge clk)
    disable iff (rst)
    ded_level_req[1] && global_irq_enable && ext_irq_enable_mask[1]
    |=> ded_irq_req[1])
    else $error("level request not raised");

  // each edge sense mode (01, 10, 11) as a step on the gated pin seen over two edges
  sequence s_ded0_toggles;
    $changed(ded_gated[0]) &&
      sense_of(ext_irq_sense_control, 0) == ext_irq_pkg::SENSE_ANY;
  endsequence

  sequence s_ded1_falls;
    $fell(ded_gated[1]) &&
      sense_of(ext_irq_sense_control, 1) == ext_irq_pkg::SENSE_FALL;
  endsequence

  sequence s_ded2_rises;
    $rose(ded_gated[2]) &&
      sense_of(ext_irq_sense_control, 2) == ext_irq_pkg::SENSE_RISE;
  endsequence

  a_any_edge_sets: assert property (@(posedge clk)
    disable iff (rst) s_ded0_toggles |=> ext_irq_flags[0])
    else $error("toggle did not set flag");

  a_fall_sets_flag: assert property (@(posedge clk)
    disable iff (rst) s_ded1_falls |=> ext_irq_flags[1])
    else $error("falling edge did not set flag");

  a_rise_sets_flag: assert property (@(posedge clk)
    disable iff (rst) s_ded2_rises |=> ext_irq_flags[2])
    else $error("rising edge did not set flag");

  // pc_stable moves on every settled change, masked or not; with the mask bit set the change is accepted
  sequence s_pc0_accepted;
    $changed(pc_stable[0]) && $past(bank_pin_mask[0][0]);
  endsequence

  a_bank_flag_set: assert property (@(posedge clk)
    disable iff (rst) s_pc0_accepted |-> pin_change_bank_flags[0])
    else $error("bank flag not set");

  a_ack_clears: assert property (@(posedge clk)
    disable iff (rst) ded_irq_ack[0] && !ded_event[0] |=> !ext_irq_flags[0])
    else $error("acknowledge did not clear flag");

endmodule

// [testbench/ext_pin_change_irq_tb_top.sv]
// self-checking bench of the pin interrupt block
`timescale 1ns/1ps
module ext_pin_change_irq_tb_top;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pin_change_inputs;
  logic [2:0] dedicated_irq_pins, ded_irq_ack, ded_irq_req;
  logic [3:0] bank_irq_ack, pin_change_bank_irq;
  logic [6:0] irq_all;
  int fail_count;
  int checks;
  assign irq_all = {pin_change_bank_irq, ded_irq_req};
  ext_pin_change_irq ext_pin_change_irq_inst (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dedicated_irq_pins, .pin_change_inputs, .ded_irq_ack, .bank_irq_ack,
    .ded_irq_req, .pin_change_bank_irq);
  pin_source pin_source_inst (.clk, .dedicated_irq_pins, .pin_change_inputs);

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // one apb transfer; no cycle count is assumed, the wait is only bounded
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      check(1'b0, 1'b1, "apb timeout");
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, m);
  endtask
  task automatic wait_out(input int i, input logic v);
    int n;
    n = 0;
    while (irq_all[i] !== v && n < 30) begin
      @(posedge clk);
      n++;
    end
    check(irq_all[i], v, "request level timeout");
    if (irq_all[i] !== v) begin
      summarize();
    end
  endtask
  task automatic ack(input logic [2:0] d, input logic [3:0] b);
    @(posedge clk);
    ded_irq_ack <= d;
    bank_irq_ack <= b;
    @(posedge clk);
    ded_irq_ack <= 3'h0;
    bank_irq_ack <= 4'h0;
  endtask

  task automatic test_regs();
    logic [31:0] r;
    logic e;
    rd_chk(ext_irq_pkg::ADDR_SENSE, 32'h0, "sense reset");
    rd_chk(ext_irq_pkg::ADDR_MASK, 32'h0, "mask reset");
    rd_chk(ext_irq_pkg::ADDR_BANK_EN, 32'h0, "bank enable reset");
    for (int b = 0; b < 4; b++) begin
      rd_chk(ext_irq_pkg::ADDR_PIN_MASK0 + 12'(4 * b), 32'h0, "pin mask");
    end
    wr(ext_irq_pkg::ADDR_SENSE, 32'hff);
    rd_chk(ext_irq_pkg::ADDR_SENSE, 32'h3f, "reserved sense bits");
    wr(ext_irq_pkg::ADDR_SENSE, 32'h0);
    wr(ext_irq_pkg::ADDR_PIN_MASK0 + 12'h8, 32'ha5);
    rd_chk(ext_irq_pkg::ADDR_PIN_MASK0 + 12'h8, 32'ha5, "pin mask rw");
    wr(ext_irq_pkg::ADDR_PIN_MASK0 + 12'h8, 32'h0);
    apb(1'b0, 12'h030, 32'h0, r, e);
    check(e, 1'b1, "unmapped error");
    check(r, 32'h0, "unmapped data");
    $display("test_regs done");
  endtask
  // sense modes 01, 10, 11 on pins 0, 1, 2 in turn
  task automatic test_edges();
    logic [2:0] p;
    for (int m = 1; m < 4; m++) begin
      p = 3'(1 << (m - 1));
      wr(ext_irq_pkg::ADDR_CTRL, 32'h1);
      wr(ext_irq_pkg::ADDR_MASK, 32'h0);
      wr(ext_irq_pkg::ADDR_SENSE, 32'(m << (2 * (m - 1))));
      wr(ext_irq_pkg::ADDR_FLAGS, 32'h7);
      wr(ext_irq_pkg::ADDR_MASK, 32'(p));
      pin_source_inst.drive_ded(m - 1, 1'b0);
      rd_chk(ext_irq_pkg::ADDR_FLAGS, (m == 3) ? 32'h0 : 32'(p), "fall");
      check(ded_irq_req, (m == 3) ? 3'h0 : p, "fall request");
      ack(p, 4'h0);
      rd_chk(ext_irq_pkg::ADDR_FLAGS, 32'h0, "ack clear");
      pin_source_inst.drive_ded(m - 1, 1'b1);
      rd_chk(ext_irq_pkg::ADDR_FLAGS, (m == 2) ? 32'h0 : 32'(p), "rise");
      wr(ext_irq_pkg::ADDR_CTRL, 32'h0);
      wait_out(m - 1, 1'b0);
      wr(ext_irq_pkg::ADDR_FLAGS, 32'(p));
      rd_chk(ext_irq_pkg::ADDR_FLAGS, 32'h0, "write one clear");
    end
    $display("test_edges done");
  endtask
  task automatic test_level();
    wr(ext_irq_pkg::ADDR_MASK, 32'h0);
    wr(ext_irq_pkg::ADDR_SENSE, 32'h0);
    wr(ext_irq_pkg::ADDR_CTRL, 32'h1);
    wr(ext_irq_pkg::ADDR_MASK, 32'h2);
    pin_source_inst.drive_ded(1, 1'b0);
    wait_out(1, 1'b1);
    rd_chk(ext_irq_pkg::ADDR_FLAGS, 32'h0, "level flag");
    ack(3'h2, 4'h0);
    repeat (4) @(posedge clk);
    check(ded_irq_req, 3'h2, "level request held");
    wr(ext_irq_pkg::ADDR_MASK, 32'h0);
    wait_out(1, 1'b0);
    pin_source_inst.drive_ded(1, 1'b1);
    $display("test_level done");
  endtask
  task automatic test_banks();
    logic [11:0] ma;
    logic [3:0] fb;
    for (int b = 0; b < 4; b++) begin
      ma = ext_irq_pkg::ADDR_PIN_MASK0 + 12'(4 * b);
      fb = 4'(1 << b);
      wr(ext_irq_pkg::ADDR_CTRL, 32'h1);
      wr(ext_irq_pkg::ADDR_BANK_EN, 32'hf);
      wr(ma, 32'(8'h1 << b));
      pin_source_inst.toggle_pc(9 * b + 1);
      rd_chk(ext_irq_pkg::ADDR_BANK_FLAGS, 32'h0, "masked pin");
      pin_source_inst.toggle_pc(9 * b);
      rd_chk(ext_irq_pkg::ADDR_BANK_FLAGS, 32'(fb), "bank flag");
      check(pin_change_bank_irq, fb, "bank request");
      wr(ext_irq_pkg::ADDR_BANK_EN, 32'(~fb));
      wait_out(3 + b, 1'b0);
      if (b[0]) begin
        wr(ext_irq_pkg::ADDR_BANK_FLAGS, 32'(fb));
      end else begin
        ack(3'h0, fb);
      end
      rd_chk(ext_irq_pkg::ADDR_BANK_FLAGS, 32'h0, "bank clear");
      wr(ma, 32'h0);
    end
    $display("test_banks done");
  endtask
  // sleep with a pin disabled gates it low: a falling edge that sets its flag
  task automatic test_sleep();
    rd_chk(ext_irq_pkg::ADDR_PIN_STATE, 32'h180c0603, "pc state");
    wr(ext_irq_pkg::ADDR_MASK, 32'h0);
    wr(ext_irq_pkg::ADDR_SENSE, 32'h2);
    wr(ext_irq_pkg::ADDR_FLAGS, 32'h7);
    rd_chk(ext_irq_pkg::ADDR_DED_STATE, 32'h7, "ded state");
    wr(ext_irq_pkg::ADDR_CTRL, 32'h2);
    rd_chk(ext_irq_pkg::ADDR_FLAGS, 32'h1, "sleep gating flag");
    check(ded_irq_req, 3'h0, "masked sleep request");
    wr(ext_irq_pkg::ADDR_CTRL, 32'h0);
    wr(ext_irq_pkg::ADDR_FLAGS, 32'h1);
    rd_chk(ext_irq_pkg::ADDR_FLAGS, 32'h0, "sleep flag clear");
    $display("test_sleep done");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ded_irq_ack = 3'h0;
    bank_irq_ack = 4'h0;
    fail_count = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_edges();
    test_level();
    test_banks();
    test_sleep();
    summarize();
  end
endmodule

// [testbench/pin_source.sv]
// partner model: external sources that drive the interrupt pins
`timescale 1ns/1ps
module pin_source (
  input wire logic clk,
  output logic [2:0] dedicated_irq_pins,
  output logic [31:0] pin_change_inputs
);
  // dedicated pins idle high, so leaving reset shows no edge
  initial begin
    dedicated_irq_pins = 3'h7;
    pin_change_inputs = 32'h0;
  end
  // each new level is held past the minimum pulse width before any change
  task automatic drive_ded(input int p, input logic v);
    @(posedge clk);
    dedicated_irq_pins[p] <= v;
    repeat (ext_irq_pkg::MIN_PULSE_CYC + 2) @(posedge clk);
  endtask
  task automatic toggle_pc(input int p);
    @(posedge clk);
    pin_change_inputs[p] <= ~pin_change_inputs[p];
    repeat (ext_irq_pkg::MIN_PULSE_CYC + 2) @(posedge clk);
  endtask
endmodule
